// ---- design/idcd_pkg.sv ----
// constants, opcodes and types for the instruction decode tail
package idcd_pkg;

    // ------------------------------------------------------------
    // opcodes handled here
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SOFT_INT   = 8'h83;
    localparam logic [7:0] OP_ACC_TO_IDX = 8'h97;
    localparam logic [7:0] OP_IDX_TO_ACC = 8'h9f;
    localparam logic [7:0] OP_WAIT       = 8'h8f;
    localparam logic [7:0] OP_TST_DIR    = 8'h3d;
    localparam logic [7:0] OP_TST_ACC    = 8'h4d;
    localparam logic [7:0] OP_TST_IDX    = 8'h5d;
    localparam logic [7:0] OP_TST_IX1    = 8'h6d;
    localparam logic [7:0] OP_TST_IX     = 8'h7d;
    localparam logic [7:0] OP_JMP_DIR    = 8'hbc;
    localparam logic [7:0] OP_JMP_EXT    = 8'hcc;
    localparam logic [7:0] OP_JMP_IX2    = 8'hdc;
    localparam logic [7:0] OP_JMP_IX1    = 8'hec;
    localparam logic [7:0] OP_JMP_IX     = 8'hfc;
    localparam logic [7:0] OP_BRA        = 8'h20;
    localparam logic [7:0] OP_BRN        = 8'h21;
    localparam logic [7:0] OP_BNE        = 8'h26;
    localparam logic [7:0] OP_BEQ        = 8'h27;
    localparam logic [3:0] NIB_BIT_BR    = 4'h0;

    // ------------------------------------------------------------
    // cycle counts, counted from the opcode fetch
    // ------------------------------------------------------------
    localparam logic [3:0] CYC_SOFT_INT = 4'ha;
    localparam logic [3:0] CYC_XFER     = 4'h2;
    localparam logic [3:0] CYC_TST_DIR  = 4'h4;
    localparam logic [3:0] CYC_TST_INH  = 4'h3;
    localparam logic [3:0] CYC_TST_IX1  = 4'h5;
    localparam logic [3:0] CYC_TST_IX   = 4'h4;
    localparam logic [3:0] CYC_WAIT     = 4'h2;
    localparam logic [3:0] CYC_MIN      = 4'h0;

    // software interrupt step numbers
    localparam logic [3:0] STEP_PCL  = 4'h2;
    localparam logic [3:0] STEP_PCH  = 4'h3;
    localparam logic [3:0] STEP_IDX  = 4'h4;
    localparam logic [3:0] STEP_ACC  = 4'h5;
    localparam logic [3:0] STEP_FLG  = 4'h6;
    localparam logic [3:0] STEP_VHI  = 4'h7;
    localparam logic [3:0] STEP_VLO  = 4'h8;

    // ------------------------------------------------------------
    // flag register layout and reset values
    // ------------------------------------------------------------
    localparam int FLG_H = 4;
    localparam int FLG_I = 3;
    localparam int FLG_N = 2;
    localparam int FLG_Z = 1;
    localparam int FLG_C = 0;
    localparam logic [7:0]  FLAGS_RESET = 8'he8;
    localparam logic [15:0] SP_RESET    = 16'h00ff;
    localparam logic [7:0]  PAGE_ZERO   = 8'h00;

    // addressing modes of the operand path
    typedef enum logic [2:0] {
        M_DIR = 3'h0,
        M_EXT = 3'h1,
        M_IX2 = 3'h2,
        M_IX1 = 3'h3,
        M_IX  = 3'h4
    } idcd_mode_t;

    // sequencer states, one-hot
    typedef enum logic [7:0] {
        S_FETCH  = 8'h01,
        S_DECODE = 8'h02,
        S_OPND   = 8'h04,
        S_OPND2  = 8'h08,
        S_DATA   = 8'h10,
        S_PUSH   = 8'h20,
        S_VEC    = 8'h40,
        S_HALT   = 8'h80
    } idcd_state_t;

    // addressing mode from the opcode column
    function automatic idcd_mode_t idcd_mode_of(input logic [7:0] opc);
        case (opc[7:4])
            4'hc:        return M_EXT;
            4'hd:        return M_IX2;
            4'h6, 4'he:  return M_IX1;
            4'h7, 4'hf:  return M_IX;
            default:     return M_DIR;
        endcase
    endfunction

    // documented cycle totals; zero means as many as used
    function automatic logic [3:0] idcd_cycles(input logic [7:0] opc);
        case (opc)
            OP_SOFT_INT:                return CYC_SOFT_INT;
            OP_ACC_TO_IDX, OP_IDX_TO_ACC: return CYC_XFER;
            OP_TST_DIR:                 return CYC_TST_DIR;
            OP_TST_ACC, OP_TST_IDX:     return CYC_TST_INH;
            OP_TST_IX1:                 return CYC_TST_IX1;
            OP_TST_IX:                  return CYC_TST_IX;
            OP_WAIT:                    return CYC_WAIT;
            default:                    return CYC_MIN;
        endcase
    endfunction

endpackage

// ---- design/idcd_addr_gen.sv ----
// effective address and branch target generation
`timescale 1ns/1ps

module idcd_addr_gen
    import idcd_pkg::*;
(
    // operand sources
    input  wire idcd_mode_t  mode,
    input  wire logic [7:0]  idx,
    input  wire logic [7:0]  op_hi,
    input  wire logic [7:0]  op_lo,
    input  wire logic [15:0] pc,
    input  wire logic [7:0]  rel,
    // results
    output logic      [15:0] ea,
    output logic      [15:0] br_target
);

    logic [15:0] idx_wide;

    // ------------------------------------------------------------
    // operand address
    // ------------------------------------------------------------
    assign idx_wide = {PAGE_ZERO, idx};

    // address per mode
    always_comb begin
        case (mode)
            M_EXT:   ea = {op_hi, op_lo};
            M_IX2:   ea = idx_wide + {op_hi, op_lo};
            M_IX1:   ea = idx_wide + {PAGE_ZERO, op_hi};
            M_IX:    ea = idx_wide;
            default: ea = {PAGE_ZERO, op_hi};
        endcase
    end

    // ------------------------------------------------------------
    // branch target
    // ------------------------------------------------------------
    // signed displacement on pc
    assign br_target = pc + {{8{rel[7]}}, rel};

endmodule

// ---- design/idcd_core.sv ----
// decode and sequencing of the control and transfer instruction tail
`timescale 1ns/1ps

// How it works
// - soft interrupt, ten cycles, pushes, vectors
// - acc to index, two cycles, flags kept
// - index to acc, two cycles, flags kept
// - test sets sign, zero; five opcodes
// - wait halts cpu, clears interrupt mask
// - short offset added unsigned to index
// - long offset high byte first, plus index
// - full address high byte then low
// - bit branch: address byte, then offset
// - relative offset signed onto pc
// - plain indexed uses index, no operand
module idcd_core
    import idcd_pkg::*;
#(
    parameter logic [15:0] SOFT_VEC_ADDR = 16'hfffc,
    parameter logic [15:0] RESET_PC      = 16'h0000
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // program and data memory
    output logic      [15:0] mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    // wake up
    input  wire logic        irq_pending,
    // core state view
    output logic      [7:0]  acc,
    output logic      [7:0]  idx,
    output logic      [15:0] sp,
    output logic      [15:0] pc,
    output logic      [7:0]  flags,
    output logic             cpu_halted,
    output logic             illegal_op
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        idcd_state_t state;
        logic [3:0]  cyc;
        logic [7:0]  opc;
        logic [7:0]  op1;
        logic [7:0]  op2;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [7:0]  acc;
        logic [7:0]  idx;
        logic [7:0]  flags;
        logic        halted;
        logic        illegal;
        logic        pad;
    } idcd_st_t;

    idcd_st_t    q;
    idcd_st_t    d;
    logic [3:0]  total;
    logic        fin;
    logic [7:0]  op_hi;
    logic [7:0]  op_lo;
    logic [7:0]  rel;
    logic [15:0] ea;
    logic [15:0] br_target;
    logic        bit_val;

    // ------------------------------------------------------------
    // operand address path
    // ------------------------------------------------------------
    // operand bytes are taken straight off the bus in the cycle they land
    assign op_hi = (q.state == S_OPND) ? mem_rdata : q.op1;
    assign op_lo = (q.state == S_OPND2) ? mem_rdata : q.op2;
    assign rel   = (q.state == S_DATA) ? q.op2 : op_hi;

    idcd_addr_gen u_addr (
        .mode      (idcd_mode_of(q.opc)),
        .idx       (q.idx),
        .op_hi     (op_hi),
        .op_lo     (op_lo),
        .pc        (q.pc),
        .rel       (rel),
        .ea        (ea),
        .br_target (br_target)
    );

    // tested bit of a bit branch
    assign bit_val = mem_rdata[q.opc[3:1]];

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // next state, memory requests and register updates
    always_comb begin
        d         = q;
        d.cyc     = q.cyc + 4'h1;
        d.illegal = 1'b0;
        d.pad     = 1'b0;
        mem_rd    = 1'b0;
        mem_wr    = 1'b0;
        mem_addr  = q.pc;
        mem_wdata = 8'h00;
        fin       = 1'b0;
        total     = idcd_cycles(q.opc);
        case (q.state)
            S_FETCH: begin
                mem_rd = 1'b1;
                d.pc   = q.pc + 16'h0001;
                d.cyc  = 4'h1;
                d.state = S_DECODE;
            end
            S_DECODE: begin
                d.opc = mem_rdata;
                total = idcd_cycles(mem_rdata);
                case (mem_rdata)
                    OP_SOFT_INT: d.state = S_PUSH;
                    OP_ACC_TO_IDX: begin
                        d.idx = q.acc;
                        fin   = 1'b1;
                    end
                    OP_IDX_TO_ACC: begin
                        d.acc = q.idx;
                        fin   = 1'b1;
                    end
                    OP_TST_ACC: begin
                        d.flags[FLG_N] = q.acc[7];
                        d.flags[FLG_Z] = (q.acc == 8'h00);
                        fin = 1'b1;
                    end
                    OP_TST_IDX: begin
                        d.flags[FLG_N] = q.idx[7];
                        d.flags[FLG_Z] = (q.idx == 8'h00);
                        fin = 1'b1;
                    end
                    OP_TST_IX: begin
                        mem_rd   = 1'b1;
                        mem_addr = {PAGE_ZERO, q.idx};
                        d.state  = S_DATA;
                    end
                    OP_JMP_IX: begin
                        d.pc = {PAGE_ZERO, q.idx};
                        fin  = 1'b1;
                    end
                    OP_WAIT: begin
                        d.flags[FLG_I] = 1'b0;
                        d.halted       = 1'b1;
                        d.state        = S_HALT;
                    end
                    OP_TST_DIR, OP_TST_IX1, OP_JMP_DIR, OP_JMP_EXT,
                    OP_JMP_IX2, OP_JMP_IX1, OP_BRA, OP_BRN, OP_BNE, OP_BEQ: begin
                        mem_rd  = 1'b1;
                        d.pc    = q.pc + 16'h0001;
                        d.state = S_OPND;
                    end
                    default: begin
                        if (mem_rdata[7:4] == NIB_BIT_BR) begin
                            mem_rd  = 1'b1;
                            d.pc    = q.pc + 16'h0001;
                            d.state = S_OPND;
                        end else begin
                            d.illegal = 1'b1;
                            fin       = 1'b1;
                        end
                    end
                endcase
            end
            S_OPND: begin
                d.op1 = mem_rdata;
                case (q.opc)
                    OP_TST_DIR, OP_TST_IX1: begin
                        mem_rd   = 1'b1;
                        mem_addr = ea;
                        d.state  = S_DATA;
                    end
                    OP_JMP_DIR, OP_JMP_IX1: begin
                        d.pc = ea;
                        fin  = 1'b1;
                    end
                    OP_BRA: begin
                        d.pc = br_target;
                        fin  = 1'b1;
                    end
                    OP_BRN: fin = 1'b1;
                    OP_BNE: begin
                        if (!q.flags[FLG_Z]) begin
                            d.pc = br_target;
                        end
                        fin = 1'b1;
                    end
                    OP_BEQ: begin
                        if (q.flags[FLG_Z]) begin
                            d.pc = br_target;
                        end
                        fin = 1'b1;
                    end
                    default: begin
                        mem_rd  = 1'b1;
                        d.pc    = q.pc + 16'h0001;
                        d.state = S_OPND2;
                    end
                endcase
            end
            S_OPND2: begin
                d.op2 = mem_rdata;
                if (q.opc[7:4] == NIB_BIT_BR) begin
                    mem_rd   = 1'b1;
                    mem_addr = {PAGE_ZERO, q.op1};
                    d.state  = S_DATA;
                end else begin
                    d.pc = ea;
                    fin  = 1'b1;
                end
            end
            S_DATA: begin
                if (q.pad) begin
                    // pad cycle only counts time
                    fin = 1'b1;
                end else if (q.opc[7:4] == NIB_BIT_BR) begin
                    d.flags[FLG_C] = bit_val;
                    if (bit_val == !q.opc[0]) begin
                        d.pc = br_target;
                    end
                end else begin
                    d.flags[FLG_N] = mem_rdata[7];
                    d.flags[FLG_Z] = (mem_rdata == 8'h00);
                end
                fin = 1'b1;
            end
            S_PUSH: begin
                mem_wr   = 1'b1;
                mem_addr = q.sp;
                d.sp     = q.sp - 16'h0001;
                case (q.cyc)
                    STEP_PCL: mem_wdata = q.pc[7:0];
                    STEP_PCH: mem_wdata = q.pc[15:8];
                    STEP_IDX: mem_wdata = q.idx;
                    STEP_ACC: mem_wdata = q.acc;
                    default:  mem_wdata = q.flags;
                endcase
                if (q.cyc == STEP_FLG) begin
                    d.flags[FLG_I] = 1'b1;
                    d.state        = S_VEC;
                end
            end
            S_VEC: begin
                mem_rd = (q.cyc != CYC_SOFT_INT - 4'h1);
                if (q.cyc == STEP_VHI) begin
                    mem_addr = SOFT_VEC_ADDR;
                end else if (q.cyc == STEP_VLO) begin
                    mem_addr = SOFT_VEC_ADDR + 16'h0001;
                    d.op1    = mem_rdata;
                end else begin
                    d.pc = {q.op1, mem_rdata};
                    fin  = 1'b1;
                end
            end
            S_HALT: begin
                d.cyc = q.cyc;
                if (irq_pending) begin
                    d.halted = 1'b0;
                    d.state  = S_FETCH;
                end
            end
            default: d.state = S_FETCH;
        endcase
        // pad out to the documented cycle total
        if (fin) begin
            d.state = S_FETCH;
        end
        // pad cycles idle in the data state and leave the flags alone
        if (fin && (q.cyc + 4'h1 < total)) begin
            d.state = S_DATA;
            d.pad   = 1'b1;
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (reset) begin
            q.state   <= S_FETCH;
            q.cyc     <= 4'h0;
            q.opc     <= 8'h00;
            q.op1     <= 8'h00;
            q.op2     <= 8'h00;
            q.pc      <= RESET_PC;
            q.sp      <= SP_RESET;
            q.acc     <= 8'h00;
            q.idx     <= 8'h00;
            q.flags   <= FLAGS_RESET;
            q.halted  <= 1'b0;
            q.illegal <= 1'b0;
            q.pad     <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign acc        = q.acc;
    assign idx        = q.idx;
    assign sp         = q.sp;
    assign pc         = q.pc;
    assign flags      = q.flags;
    assign cpu_halted = q.halted;
    assign illegal_op = q.illegal;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic dec_now;
    assign dec_now = (q.state == S_DECODE);

    soft_int_len_a: assert property (dec_now && mem_rdata == OP_SOFT_INT |-> ##9 q.state == S_FETCH)
        else $error("soft interrupt not ten cycles");
    soft_int_mask_a: assert property (dec_now && mem_rdata == OP_SOFT_INT |-> ##6 q.flags[FLG_I])
        else $error("mask not set by soft interrupt");
    push_first_a: assert property (q.state == S_PUSH && q.cyc == STEP_PCL
                                  |-> mem_wr && mem_wdata == q.pc[7:0])
        else $error("first push is not pc low");
    acc_idx_a: assert property (dec_now && mem_rdata == OP_ACC_TO_IDX
                                |=> q.idx == $past(q.acc) && $stable(q.flags) && q.state == S_FETCH)
        else $error("accumulator to index wrong");
    idx_acc_a: assert property (dec_now && mem_rdata == OP_IDX_TO_ACC
                                |=> q.acc == $past(q.idx) && $stable(q.flags))
        else $error("index to accumulator wrong");
    test_acc_a: assert property (dec_now && mem_rdata == OP_TST_ACC
                                 |=> q.flags[FLG_Z] == (q.acc == 8'h00) ##1 q.state == S_FETCH)
        else $error("test of accumulator wrong");
    pad_flags_a: assert property (q.state == S_DATA && q.pad |=> $stable(q.flags))
        else $error("pad cycle changed the flags");
    wait_halt_a: assert property (dec_now && mem_rdata == OP_WAIT
                                  |=> cpu_halted && !q.flags[FLG_I])
        else $error("wait did not halt");
    short_ea_a: assert property (q.state == S_OPND && q.opc == OP_TST_IX1
                                 |-> mem_rd && mem_addr == {PAGE_ZERO, q.idx} + {PAGE_ZERO, mem_rdata})
        else $error("short offset address wrong");
    full_addr_a: assert property (q.state == S_OPND2 && q.opc == OP_JMP_EXT
                                  |=> q.pc == {$past(q.op1), $past(mem_rdata)})
        else $error("full address order wrong");
    plain_ix_a: assert property (dec_now && mem_rdata == OP_TST_IX
                                 |-> mem_rd && mem_addr == {PAGE_ZERO, q.idx})
        else $error("plain indexed address wrong");
    stack_drop_a: assert property (dec_now && mem_rdata == OP_SOFT_INT
                                   |-> ##6 q.sp == $past(q.sp, 5) - 16'h0005)
        else $error("stack pointer not down by five");

    soft_int_c: cover property (dec_now && mem_rdata == OP_SOFT_INT);
    wait_wake_c: cover property (q.state == S_HALT && irq_pending);
    bit_br_c: cover property (q.state == S_DATA && q.opc[7:4] == NIB_BIT_BR);
    jmp_ix2_c: cover property (q.state == S_OPND2 && q.opc == OP_JMP_IX2);

endmodule

// ---- verif/idcd_mem_model.sv ----
// memory model on the far side of the core's memory port
`timescale 1ns/1ps

module idcd_mem_model (
    // clock
    input  wire logic        clk,
    // request side
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    // answer side
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [0:65535];

    initial begin
        mem_rdata = 8'h5a;
    end

    // store pushes; answer reads one cycle later
    always @(posedge clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata; // idle bus does not hold
    end
endmodule

// ---- verif/test_idcd_core.sv ----
// self-checking bench for the instruction decode tail
`timescale 1ns/1ps

module test_idcd_core
    import idcd_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        irq_pending = 1'b0;
    logic [15:0] mem_addr, sp, pc, exp_pc;
    logic        mem_rd, mem_wr, cpu_halted, illegal_op;
    logic [7:0]  mem_wdata, mem_rdata, acc, idx, flags, d_rand, b_rand;
    logic [23:0] wr_q[$];
    logic [23:0] img[];
    int          bad_count = 0;
    int          n_checks = 0;
    int          seed = 94;
    int          cyc = 0;
    int          last = 0;

    idcd_core dut_u (.clk(clk), .reset(reset), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .irq_pending(irq_pending), .acc(acc), .idx(idx), .sp(sp), .pc(pc),
        .flags(flags), .cpu_halted(cpu_halted), .illegal_op(illegal_op));

    idcd_mem_model mem_u (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            test_done();
        end
    end

    // value comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // stack write comparison
    task automatic chk_wr(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t push got %h exp %h", $time, got, exp);
        end
    endtask

    // wait for an opcode fetch at a, then compare the cycles used
    task automatic run_to(input logic [15:0] a, input int n);
        int k;
        k = 0;
        while (!(mem_rd === 1'b1 && mem_addr === a) && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 200) begin
            bad_count++;
            $display("BAD %0t no fetch at %h", $time, a);
        end
        if (n != 0) chk(16'(cyc - last), 16'(n), "cycles");
        last = cyc;
    endtask

    task automatic test_done();
        bad_count += wr_q.size();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // scoreboard: each push taken against the oldest note
    always @(posedge clk) begin
        if (mem_wr === 1'b1) begin
            chk_wr({mem_addr, mem_wdata}, wr_q.size() > 0 ? wr_q.pop_front() : 24'hxxxxxx);
        end
    end

    // program image, reset and instruction walk
    initial begin
        d_rand = 8'($random(seed));
        b_rand = 8'($random(seed));
        img = '{24'h00003d, 24'h000140, 24'h00026d, 24'h000310, 24'h00047d, 24'h00054d,
                24'h000697, 24'h00079f, 24'h000883, 24'hfffc01, 24'hfffd00, 24'h0100cc,
                24'h010102, 24'h010200, 24'h020020, 24'h020102, 24'h020420, 24'h0205f0,
                24'h01f68f, 24'h01f7ec, 24'h01f830, 24'h003001, 24'h003150, 24'h003205,
                24'h00339d, 24'h00389d, 24'h001000};
        foreach (img[i]) mem_u.mem[img[i][23:8]] = img[i][7:0];
        mem_u.mem[16'h0040] = d_rand;
        mem_u.mem[16'h0050] = b_rand;
        wr_q = '{24'h00ff09, 24'h00fe00, 24'h00fd00, 24'h00fc00, 24'h00fbea};
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        #1;
        run_to(16'h0000, 0);
        run_to(16'h0002, 4);
        chk(16'(flags), {8'h00, 5'b11101, d_rand[7], d_rand == 8'h00, 1'b0}, "tst dir");
        run_to(16'h0004, 5);
        chk(16'(flags), 16'h00ea, "tst ix1");
        run_to(16'h0005, 4);
        chk(16'(flags), 16'h00e8, "tst ix");
        run_to(16'h0006, 3);
        run_to(16'h0007, 2);
        chk(16'(flags), 16'h00ea, "tax flags");
        run_to(16'h0008, 2);
        chk({idx, acc}, 16'h0000, "txa regs");
        run_to(16'h0100, 10);
        chk(sp, 16'h00fa, "sp");
        chk(16'(flags[FLG_I]), 16'h0001, "mask");
        run_to(16'h0200, 0);
        run_to(16'h0204, 3);
        run_to(16'h01f6, 3);
        repeat (3) @(posedge clk);
        #1;
        chk({flags, 7'h00, cpu_halted}, 16'he201, "wait");
        @(posedge clk);
        irq_pending <= 1'b1;
        run_to(16'h01f7, 0);
        irq_pending <= 1'b0;
        run_to(16'h0030, 0);
        exp_pc = b_rand[0] ? 16'h0033 : 16'h0038;
        run_to(exp_pc, 5);
        chk(16'(flags[FLG_C]), 16'(b_rand[0]), "bit");
        repeat (4) begin
            @(posedge clk);
            #1;
            if (illegal_op === 1'b1) break;
        end
        chk(16'(illegal_op), 16'h0001, "illegal");
        test_done();
    end
endmodule
